// ---- core/ctsup_core.sv ----
// CT circuit supervision: pick-up evaluation, blocking, definite-time alarm and readouts.
`timescale 1ns/1ps
module ctsup_core #(
  parameter int STEP_CYCLES = ctsup_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // Measurement chain
  input  wire logic                   program_tick,
  input  wire ctsup_pkg::ctsup_meas_t meas,
  // Blocking matrix
  input  wire logic                   block_in,
  // Settings and commands
  input  wire ctsup_pkg::ctsup_cfg_t  cfg,
  input  wire logic                   comp_cmd,
  // Status and readouts
  output logic                        start,
  output logic                        blocked,
  output logic                        alarm,
  output ctsup_pkg::ctsup_read_t      readout
);

  localparam int SUB_W = $clog2(STEP_CYCLES + 1);
  localparam int MW    = ctsup_pkg::MAG_W;
  localparam int AW    = ctsup_pkg::ANG_W;
  localparam int CW    = ctsup_pkg::CMP_W;
  localparam int NC    = ctsup_pkg::NUM_CMP;

  typedef struct packed {
    ctsup_pkg::ctsup_state_t state;
    logic                    tick_d;
    logic                    blk_s;
    logic [SUB_W-1:0]        sub;
    logic [ctsup_pkg::DLY_W-1:0] steps;
    logic [MW-1:0]           nat_mag;
    logic signed [AW-1:0]    nat_ang;
    ctsup_pkg::ctsup_read_t  rd;
  } ctsup_core_t;

  ctsup_core_t          q;
  ctsup_core_t          next_q;
  logic [MW-1:0]        ph_max;
  logic [MW-1:0]        ph_min;
  logic [NC-1:0][CW-1:0] cmp_val;
  logic [NC-1:0][CW-1:0] cmp_lim;
  logic [NC-1:0]        cmp_act;
  logic                 pick;
  logic                 timer_done;
  logic signed [AW-1:0] res_ang_eff;

  // Keeps an angle difference inside plus or minus a full turn.
  function automatic logic signed [AW-1:0] wrap_ang(input logic signed [AW-1:0] a,
                                                    input logic signed [AW-1:0] b);
    logic signed [AW:0] d;
    logic signed [AW:0] full;
    // Both sides are kept signed, or a negative difference would compare as a huge value.
    full = {1'b0, ctsup_pkg::ANG_FULL};
    d    = $signed({a[AW-1], a}) - $signed({b[AW-1], b});
    if (d > full)
      d = d - full;
    else if (d < -full)
      d = d + full;
    return d[AW-1:0];
  endfunction

  function automatic logic [MW-1:0] abs_diff(input logic [MW-1:0] a, input logic [MW-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  always_comb
  begin
    ph_max = meas.phase[0];
    ph_min = meas.phase[0];
    for (int i = 1; i < 3; i++)
    begin
      if (meas.phase[i] > ph_max)
        ph_max = meas.phase[i];
      if (meas.phase[i] < ph_min)
        ph_min = meas.phase[i];
    end
  end

  // A subtracting residual connection turns the residual phasor half a turn.
  assign res_ang_eff = cfg.residual_subtract ? wrap_ang(meas.res_ang, ctsup_pkg::ANG_HALF)
                                             : meas.res_ang;

  assign cmp_val[ctsup_pkg::CMP_HIGH]  = CW'(ph_max);
  assign cmp_lim[ctsup_pkg::CMP_HIGH]  = CW'(cfg.phase_current_limit_high);
  assign cmp_val[ctsup_pkg::CMP_LOW]   = CW'(ph_max);
  assign cmp_lim[ctsup_pkg::CMP_LOW]   = CW'(cfg.phase_current_limit_low);
  // min over max against the ratio limit.
  assign cmp_val[ctsup_pkg::CMP_RATIO] = CW'(ph_min) * CW'(ctsup_pkg::RATIO_SCALE);
  assign cmp_lim[ctsup_pkg::CMP_RATIO] = CW'(cfg.min_max_ratio) * CW'(ph_max);
  assign cmp_val[ctsup_pkg::CMP_SEQ]   = CW'(meas.neg_seq) * CW'(ctsup_pkg::RATIO_SCALE);
  assign cmp_lim[ctsup_pkg::CMP_SEQ]   = CW'(cfg.sequence_ratio) * CW'(meas.pos_seq);
  assign cmp_val[ctsup_pkg::CMP_SUM]   = CW'(q.rd.cur_diff);
  assign cmp_lim[ctsup_pkg::CMP_SUM]   = CW'(cfg.sum_diff_limit);

  for (genvar g = 0; g < NC; g++)
  begin : g_cmp
    ctsup_hyst_cmp #(
      .UNDER (ctsup_pkg::CMP_UNDER[g])
    ) u_cmp (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tick    (program_tick),
      .value   (cmp_val[g]),
      .limit   (cmp_lim[g]),
      .active  (cmp_act[g])
    );
  end

  // upper limit vetoes, lower limit vetoes, residual term.
  assign pick = !cmp_act[ctsup_pkg::CMP_HIGH] && cmp_act[ctsup_pkg::CMP_LOW]
             && cmp_act[ctsup_pkg::CMP_RATIO] && cmp_act[ctsup_pkg::CMP_SEQ]
             && (!cfg.residual_current_input || cmp_act[ctsup_pkg::CMP_SUM]);

  // delay counted in whole 5 ms steps.
  assign timer_done = (q.steps >= cfg.definite_delay);

  always_comb
  begin
    next_q        = q;
    next_q.tick_d = program_tick;
    // block latched only at the program tick.
    // taken straight from the blocking-matrix input.
    if (program_tick)
      next_q.blk_s = block_in;
    if (program_tick)
    begin
      // current difference, saturated at 50 In.
      next_q.rd.cur_diff = (abs_diff(meas.sum_mag, meas.res_mag) > ctsup_pkg::DIFF_MAX)
                         ? ctsup_pkg::DIFF_MAX : abs_diff(meas.sum_mag, meas.res_mag);
      // angle difference of summed phases to residual.
      next_q.rd.ang_diff = wrap_ang(meas.sum_ang, res_ang_eff);
      next_q.rd.unb_mag  = abs_diff(meas.sum_mag, q.nat_mag);
      // compensated angle kept within one turn.
      next_q.rd.unb_ang  = wrap_ang(meas.sum_ang, q.nat_ang);
    end
    // Compensation is only meaningful with the line energised; the operator decides when.
    if (comp_cmd)
    begin
      next_q.nat_mag = meas.sum_mag;
      next_q.nat_ang = meas.sum_ang;
    end
    // a single definite-time counter, no curve.
    if (q.state == ctsup_pkg::ST_START)
    begin
      if (q.sub == SUB_W'(STEP_CYCLES - 1))
      begin
        next_q.sub   = '0;
        next_q.steps = q.steps + 1'b1;
      end
      else
        next_q.sub = q.sub + 1'b1;
    end
    unique case (q.state)
      ctsup_pkg::ST_IDLE:
        if (q.tick_d && pick)
          next_q.state = q.blk_s ? ctsup_pkg::ST_BLOCKED : ctsup_pkg::ST_START;
      ctsup_pkg::ST_START, ctsup_pkg::ST_ALARM:
        // any lost condition releases at once.
        if (q.tick_d && !pick)
          next_q.state = ctsup_pkg::ST_IDLE;
        // block releases start like a drop-out.
        else if (q.tick_d && q.blk_s)
          next_q.state = ctsup_pkg::ST_BLOCKED;
        // alarm only after the full delay.
        else if (q.state == ctsup_pkg::ST_START && timer_done)
          next_q.state = ctsup_pkg::ST_ALARM;
      ctsup_pkg::ST_BLOCKED:
        if (q.tick_d && !pick)
          next_q.state = ctsup_pkg::ST_IDLE;
        else if (q.tick_d && !q.blk_s)
          next_q.state = ctsup_pkg::ST_START;
    endcase
    // timer cleared whenever start is not held.
    if (next_q.state != ctsup_pkg::ST_START && next_q.state != ctsup_pkg::ST_ALARM)
    begin
      next_q.sub   = '0;
      next_q.steps = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign start   = (q.state == ctsup_pkg::ST_START) || (q.state == ctsup_pkg::ST_ALARM);
  assign alarm   = (q.state == ctsup_pkg::ST_ALARM);
  assign blocked = (q.state == ctsup_pkg::ST_BLOCKED);
  assign readout = q.rd;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_block_sample: assert property (program_tick |=> q.blk_s == $past(block_in))
    else $error("block not sampled at tick");
  chk_block_hold: assert property (!program_tick |=> $stable(q.blk_s))
    else $error("block sample moved between ticks");
  chk_start_raise: assert property (q.state == ctsup_pkg::ST_IDLE && q.tick_d && pick
                                    && !q.blk_s |=> start && !blocked)
    else $error("start not raised on pick-up");
  chk_block_raise: assert property (q.tick_d && pick && q.blk_s |=> blocked && !start
                                    && !alarm)
    else $error("blocked not raised on blocked pick-up");
  chk_start_drop: assert property (start && q.tick_d && q.blk_s |=> !start
                                   ##1 (q.steps == '0))
    else $error("start survived a block");
  chk_alarm_delay: assert property ($rose(alarm) |-> $past(start) && $past(timer_done))
    else $error("alarm without full delay");
  chk_high_veto: assert property (q.tick_d && cmp_act[ctsup_pkg::CMP_HIGH]
                                  |=> !start && !blocked && !alarm)
    else $error("pick-up above upper limit");
  chk_low_veto: assert property (q.tick_d && !cmp_act[ctsup_pkg::CMP_LOW]
                                 |=> !start && !blocked && !alarm)
    else $error("pick-up below lower limit");
  chk_res_term: assert property (q.tick_d && cfg.residual_current_input
                                 && !cmp_act[ctsup_pkg::CMP_SUM]
                                 |=> !start && !blocked && !alarm)
    else $error("pick-up without residual difference");
  chk_diff_range: assert property (readout.cur_diff <= ctsup_pkg::DIFF_MAX)
    else $error("current difference out of range");
  chk_angle_range: assert property (readout.unb_ang <= ctsup_pkg::ANG_FULL
                                    && readout.unb_ang >= -ctsup_pkg::ANG_FULL)
    else $error("unbalance angle out of range");
  chk_release: assert property (start && q.tick_d && !pick |=> !start && !alarm)
    else $error("start held after drop-out");

  cov_start: cover property ($rose(start));
  cov_alarm: cover property ($rose(alarm));
  cov_blocked: cover property ($rose(blocked));
  cov_start_then_block: cover property (start ##1 blocked);

endmodule // ctsup_core

// ---- core/ctsup_pkg.sv ----
// Shared constants, carriers and state codes of the CT circuit supervision block.
package ctsup_pkg;

  // Data widths: magnitudes in 0.01 x In, angles in 0.01 deg, ratios in 0.01 %.
  localparam int MAG_W = 16;
  localparam int ANG_W = 17;
  localparam int PCT_W = 14;
  localparam int DLY_W = 19;
  localparam int CMP_W = 32;

  // Comparator slots.
  localparam int NUM_CMP   = 5;
  localparam int CMP_HIGH  = 0;
  localparam int CMP_LOW   = 1;
  localparam int CMP_RATIO = 2;
  localparam int CMP_SEQ   = 3;
  localparam int CMP_SUM   = 4;
  localparam logic [NUM_CMP-1:0] CMP_UNDER = 5'h04;

  // Fixed hysteresis relative to the limit, in percent.
  localparam int HYST_DROP_PCT = 97;
  localparam int HYST_RISE_PCT = 103;
  localparam int PCT_UNIT      = 100;
  localparam int RATIO_SCALE   = 10000;

  // Readout limits.
  localparam logic [MAG_W-1:0]        DIFF_MAX = 16'h1388;
  localparam logic signed [ANG_W-1:0] ANG_FULL = 17'h08CA0;
  localparam logic signed [ANG_W-1:0] ANG_HALF = 17'h04650;

  // Setting defaults.
  localparam logic [MAG_W-1:0] HIGH_DEF      = 16'h0078;
  localparam logic [MAG_W-1:0] LOW_DEF       = 16'h000A;
  localparam logic [PCT_W-1:0] RATIO_DEF     = 14'h03E8;
  localparam logic [PCT_W-1:0] SEQ_RATIO_DEF = 14'h1324;
  localparam logic [MAG_W-1:0] SUM_DIFF_DEF  = 16'h000A;
  localparam logic [DLY_W-1:0] DELAY_DEF     = 19'h00064;

  // Timing: alarm delay counts in 5 ms steps of the 200 MHz clock.
  localparam int SYS_CLK_MHZ   = 200;
  localparam int DELAY_STEP_US = 5000;
  localparam int STEP_CYCLES   = DELAY_STEP_US * SYS_CLK_MHZ;
  localparam int BLOCK_LEAD_MS = 5;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_START   = 2'b01,
    ST_ALARM   = 2'b11,
    ST_BLOCKED = 2'b10
  } ctsup_state_t;

  typedef struct packed {
    logic [2:0][MAG_W-1:0]    phase;
    logic [MAG_W-1:0]         pos_seq;
    logic [MAG_W-1:0]         neg_seq;
    logic [MAG_W-1:0]         sum_mag;
    logic signed [ANG_W-1:0]  sum_ang;
    logic [MAG_W-1:0]         res_mag;
    logic signed [ANG_W-1:0]  res_ang;
  } ctsup_meas_t;

  typedef struct packed {
    logic [MAG_W-1:0] phase_current_limit_high;
    logic [MAG_W-1:0] phase_current_limit_low;
    logic [PCT_W-1:0] min_max_ratio;
    logic [PCT_W-1:0] sequence_ratio;
    logic [MAG_W-1:0] sum_diff_limit;
    logic             residual_current_input;
    logic             residual_subtract;
    logic [DLY_W-1:0] definite_delay;
  } ctsup_cfg_t;

  typedef struct packed {
    logic [MAG_W-1:0]        cur_diff;
    logic signed [ANG_W-1:0] ang_diff;
    logic [MAG_W-1:0]        unb_mag;
    logic signed [ANG_W-1:0] unb_ang;
  } ctsup_read_t;

  typedef struct packed {
    logic active;
  } ctsup_cmp_t;

endpackage

// ---- core/ctsup_hyst_cmp.sv ----
// Limit comparator with fixed 97 / 103 percent hysteresis, updated once per program tick.
`timescale 1ns/1ps
module ctsup_hyst_cmp #(
  parameter bit UNDER = 1'b0
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // Compare request
  input  wire logic                        tick,
  input  wire logic [ctsup_pkg::CMP_W-1:0] value,
  input  wire logic [ctsup_pkg::CMP_W-1:0] limit,
  // Result
  output logic                             active
);

  localparam int EW = ctsup_pkg::CMP_W + 8;

  logic [EW-1:0]         v_sc;
  logic [EW-1:0]         pick_sc;
  logic [EW-1:0]         drop_sc;
  logic [EW-1:0]         rise_sc;
  ctsup_pkg::ctsup_cmp_t q;
  ctsup_pkg::ctsup_cmp_t next_q;

  assign v_sc    = EW'(value) * EW'(ctsup_pkg::PCT_UNIT);
  assign pick_sc = EW'(limit) * EW'(ctsup_pkg::PCT_UNIT);
  assign drop_sc = EW'(limit) * EW'(ctsup_pkg::HYST_DROP_PCT);
  assign rise_sc = EW'(limit) * EW'(ctsup_pkg::HYST_RISE_PCT);

  always_comb
  begin
    next_q = q;
    if (tick)
    begin
      if (!UNDER)
      begin
        if (v_sc > pick_sc)
          next_q.active = 1'b1;
        else if (v_sc < drop_sc)
          next_q.active = 1'b0;
      end
      else
      begin
        if (v_sc < pick_sc)
          next_q.active = 1'b1;
        else if (v_sc > rise_sc)
          next_q.active = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign active = q.active;

endmodule // ctsup_hyst_cmp

// ---- test/ctsup_meas_model.sv ----
// Behavioural measurement chain and blocking matrix feeding the supervision core.
`timescale 1ns/1ps
module ctsup_meas_model #(
  parameter int TICK_GAP = 40
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // Commanded values
  input  wire ctsup_pkg::ctsup_meas_t set_meas,
  input  wire logic                   set_block,
  // Toward the core
  output logic                        program_tick,
  output ctsup_pkg::ctsup_meas_t      meas,
  output logic                        block_in
);
  int   cnt;
  logic noise;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cnt          <= 0;
      program_tick <= 1'b0;
      noise        <= 1'b0;
    end
    else
    begin
      cnt          <= (cnt == TICK_GAP - 1) ? 0 : cnt + 1;
      program_tick <= (cnt == TICK_GAP - 1);
      noise        <= ~noise;
    end
  end

  assign meas = set_meas;
  // dedicated block line
  // Between ticks the line toggles every cycle, so only the value at a tick may matter.
  assign block_in = program_tick ? set_block : noise;
endmodule // ctsup_meas_model

// ---- test/testbench.sv ----
// Self-checking bench for the CT supervision core with a modelled measurement chain.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [2:0]             st;
    ctsup_pkg::ctsup_read_t rd;
  } ctsup_note_t;

  localparam int GAP = 40;

  logic                   sys_clk, rst_n, program_tick, block_in, set_block, comp_cmd;
  logic                   start, blocked, alarm, rnd;
  ctsup_pkg::ctsup_meas_t set_meas, meas;
  ctsup_pkg::ctsup_cfg_t  cfg;
  ctsup_pkg::ctsup_read_t readout;
  ctsup_note_t            notes[$];
  int                     err_count, total_checks, seed;
  logic [15:0]            sm, rm, nat_m;
  logic signed [16:0]     sa, ra, nat_a;

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ctsup_meas_model #(.TICK_GAP(GAP)) i_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .set_meas(set_meas), .set_block(set_block), .program_tick(program_tick),
    .meas(meas), .block_in(block_in));

  ctsup_core #(.STEP_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .program_tick(program_tick), .meas(meas), .block_in(block_in), .cfg(cfg),
    .comp_cmd(comp_cmd), .start(start), .blocked(blocked), .alarm(alarm), .readout(readout));

  function automatic logic [15:0] mdiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // Folds an angle back by one full turn when it lies beyond plus or minus a turn.
  function automatic logic signed [16:0] awrap(input int d);
    if (d > int'(ctsup_pkg::ANG_FULL))
      d = d - int'(ctsup_pkg::ANG_FULL);
    else if (d < -int'(ctsup_pkg::ANG_FULL))
      d = d + int'(ctsup_pkg::ANG_FULL);
    return 17'(d);
  endfunction

  task automatic cmp_st(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t status got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(input ctsup_pkg::ctsup_read_t got, input ctsup_pkg::ctsup_read_t exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t readout got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Two phases at mx, one at lo; the note is checked at the following tick.
  task automatic step(input logic [15:0] mx, input logic [15:0] lo, input logic [15:0] ps,
                      input logic [15:0] ng, input logic bk, input logic [2:0] exp);
    ctsup_note_t n;
    if (rnd)
    begin
      sm = {4'h0, 12'($random(seed))};
      rm = {4'h0, 12'($random(seed))};
      sa = 17'($signed(14'($random(seed))));
      ra = 17'($signed(14'($random(seed))));
    end
    set_meas <= '{phase: {lo, mx, mx}, pos_seq: ps, neg_seq: ng, sum_mag: sm,
                  sum_ang: sa, res_mag: rm, res_ang: ra};
    set_block <= bk;
    do @(posedge sys_clk); while (program_tick !== 1'b1);
    @(posedge sys_clk);
    n.st          = exp;
    n.rd.cur_diff = (mdiff(sm, rm) > ctsup_pkg::DIFF_MAX) ? ctsup_pkg::DIFF_MAX : mdiff(sm, rm);
    n.rd.ang_diff = awrap(int'(sa) - int'(cfg.residual_subtract
                    ? awrap(int'(ra) - int'(ctsup_pkg::ANG_HALF)) : ra));
    n.rd.unb_mag  = mdiff(sm, nat_m);
    n.rd.unb_ang  = awrap(int'(sa) - int'(nat_a));
    notes.push_back(n);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(negedge sys_clk)
  begin
    if (program_tick === 1'b1 && notes.size() > 0)
    begin
      cmp_st({start, blocked, alarm}, notes[0].st);
      cmp_rd(readout, notes[0].rd);
      void'(notes.pop_front());
    end
  end

  initial
  begin
    repeat (GAP * 40) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end

  initial
  begin
    seed         = 29061;
    err_count    = 0;
    total_checks = 0;
    rnd          = 1'b1;
    rst_n        = 1'b0;
    comp_cmd     = 1'b0;
    set_block    = 1'b0;
    set_meas     = '0;
    {sm, rm, sa, ra, nat_m, nat_a} = '0;
    cfg = '{phase_current_limit_high: ctsup_pkg::HIGH_DEF,
            phase_current_limit_low: ctsup_pkg::LOW_DEF, min_max_ratio: ctsup_pkg::RATIO_DEF,
            sequence_ratio: ctsup_pkg::SEQ_RATIO_DEF, sum_diff_limit: ctsup_pkg::SUM_DIFF_DEF,
            residual_current_input: 1'b0, residual_subtract: 1'b0, definite_delay: 19'h0000C};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b0, 3'h4);
    step(16'h64, 16'h64, 16'h64, 16'h0, 1'b0, 3'h0);
    // A one-cycle command captures the present sum as natural unbalance.
    comp_cmd <= 1'b1;
    @(posedge sys_clk);
    comp_cmd <= 1'b0;
    nat_m = sm;
    nat_a = sa;
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b0, 3'h4);
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b0, 3'h5);
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b1, 3'h2);
    step(16'h64, 16'h64, 16'h64, 16'h0, 1'b1, 3'h0);
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b1, 3'h2);
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b0, 3'h4);
    step(16'h7D, 16'h0, 16'h43, 16'h21, 1'b0, 3'h0);
    step(16'h76, 16'h0, 16'h43, 16'h21, 1'b0, 3'h0);
    cfg.definite_delay <= 19'h00000;
    step(16'h6E, 16'h0, 16'h43, 16'h21, 1'b0, 3'h5);
    step(16'h9, 16'h0, 16'h6, 16'h3, 1'b0, 3'h0);
    step(16'h64, 16'h64, 16'h43, 16'h21, 1'b0, 3'h0);
    step(16'h64, 16'h0, 16'h43, 16'h1E, 1'b0, 3'h0);
    cfg.residual_current_input <= 1'b1;
    rnd = 1'b0;
    sm  = 16'h32;
    rm  = 16'h32;
    step(16'h64, 16'h64, 16'h64, 16'h0, 1'b0, 3'h0);
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b0, 3'h0);
    sm = 16'h64;
    rm = 16'h0;
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b0, 3'h0);
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b0, 3'h5);
    // Subtracting polarity and large angles make the angle difference wrap; the current difference saturates.
    cfg.residual_subtract <= 1'b1;
    sm = 16'h1400;
    sa = 17'sh07530;
    ra = -17'sh02710;
    step(16'h64, 16'h0, 16'h43, 16'h21, 1'b0, 3'h5);
    repeat (GAP + 2) @(posedge sys_clk);
    wrap_up();
  end
endmodule // testbench
